// File: hw/fsh_ctrl.sv
// Host controller driving a stacked two-die parallel flash from Wishbone.
// Assumes a classic Wishbone master and flash pins wired directly outside.
module fsh_ctrl (
	input  wire logic        clk_i,        // System clock
	input  wire logic        rst_i,        // Synchronous reset
	input  wire logic        wb_cyc_i,     // Bus cycle
	input  wire logic        wb_stb_i,     // Strobe
	input  wire logic        wb_we_i,      // Write
	input  wire logic [7:0]  wb_adr_i,     // Byte address
	input  wire logic [3:0]  wb_sel_i,     // Byte lanes
	input  wire logic [31:0] wb_dat_i,     // Write data
	output logic [31:0]      wb_dat_o,     // Read data
	output logic             wb_ack_o,     // Acknowledge
	output logic [23:0]      addr_o,       // Flash address pins
	output logic [15:0]      dq_o,         // Flash data out
	output logic             dq_oe_o,      // Flash data drive enable
	input  wire logic [15:0] dq_i,         // Flash data in
	output logic             ce_n_o,       // Chip enable, low active
	output logic             oe_n_o,       // Output enable, low active
	output logic             we_n_o,       // Write strobe, low active
	output logic             width_sel_o,  // High for 16-bit bus
	output logic             program_erase_enable_o, // Modify enable
	output logic             reset_powerdown_n_o,    // Flash reset, low
	input  wire logic        status_ready_busy_out_i // Open-drain status
);
	// Merge written byte lanes into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = din[i*8 +: 8];
		return r;
	endfunction : merge

	logic [2:0]  ctrl, next_ctrl;
	logic [23:0] addr, next_addr;
	logic [15:0] wdata, next_wdata;
	logic [2:0]  op, next_op;
	logic [15:0] rdata, next_rdata;
	logic        done, next_done;
	logic        err, next_err;
	logic        pulse, next_pulse;
	logic        refus, next_refus;
	fsh_pkg::fsh_ct_e state, next_state;
	logic        start, next_start;
	logic        next_ack;
	logic [31:0] next_dat;
	logic        sts_s1, sts_s2, sts_s3;
	logic        bc_busy, bc_done;
	logic [15:0] bc_rdata;
	logic        wr_hit, bc_wr;
	logic [23:0] pin_addr;
	logic [15:0] bc_wdata;

	// Status pin synchroniser; third stage only feeds edge detection
	always_ff @(posedge clk_i) begin
		sts_s1 <= status_ready_busy_out_i;
		sts_s2 <= sts_s1;
		sts_s3 <= sts_s2;
	end

	// In 16-bit mode the word index moves up one bit and A0 stays low
	assign pin_addr = ctrl[fsh_pkg::CTRL_X8] ? addr : {addr[22:0], 1'b0};
	assign bc_wr    = op != fsh_pkg::OP_READ && op != fsh_pkg::OP_POLL;
	// Count word carries length minus one; range was checked at start
	assign bc_wdata = op == fsh_pkg::OP_COUNT ? wdata - 16'h0001 : wdata;
	assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	// Register file, operation sequencer and sticky flags
	always_comb begin
		next_ctrl  = ctrl;
		next_addr  = addr;
		next_wdata = wdata;
		next_op    = op;
		next_rdata = rdata;
		next_done  = done;
		next_err   = err;
		next_pulse = pulse;
		next_refus = refus;
		next_state = state;
		next_start = 1'b0;
		// Writes land on the edge where the master sees ack
		if (wr_hit) begin
			case (wb_adr_i)
				fsh_pkg::REG_CTRL:
					next_ctrl = 3'(merge(32'(ctrl), wb_dat_i, wb_sel_i));
				fsh_pkg::REG_ADDR:
					next_addr = 24'(merge(32'(addr), wb_dat_i, wb_sel_i));
				fsh_pkg::REG_WDATA:
					next_wdata = 16'(merge(32'(wdata), wb_dat_i, wb_sel_i));
				fsh_pkg::REG_STAT: if (wb_sel_i[0]) begin
					if (wb_dat_i[fsh_pkg::ST_DONE])  next_done  = 1'b0;
					if (wb_dat_i[fsh_pkg::ST_ERR])   next_err   = 1'b0;
					if (wb_dat_i[fsh_pkg::ST_PULSE]) next_pulse = 1'b0;
					if (wb_dat_i[fsh_pkg::ST_REFUS]) next_refus = 1'b0;
				end
				default: ;
			endcase
		end
		// Falling edge of the status pin is a start-of-operation pulse
		if (!sts_s2 && sts_s3)
			next_pulse = 1'b1;
		case (state)
			fsh_pkg::CT_IDLE: begin
				if (wr_hit && wb_adr_i == fsh_pkg::REG_CMD && wb_sel_i[0]) begin
					next_op = wb_dat_i[2:0];
					// Program operations need the enable pin; every operation needs a running part
					if (!ctrl[fsh_pkg::CTRL_RUN] || wb_dat_i[2:0] > fsh_pkg::OP_COUNT
						|| (wb_dat_i[2:0] == fsh_pkg::OP_PROG
						&& !ctrl[fsh_pkg::CTRL_PEEN])) begin
						next_refus = 1'b1;
					end else if (wb_dat_i[2:0] == fsh_pkg::OP_COUNT
						&& (wdata == 16'h0000 || wdata > fsh_pkg::BUF_MAX)) begin
						next_refus = 1'b1;
					end else begin
						next_start = 1'b1;
						next_state = fsh_pkg::CT_WAIT;
					end
				end
			end
			fsh_pkg::CT_WAIT: begin
				if (bc_done) begin
					next_rdata = bc_rdata;
					next_state = fsh_pkg::CT_IDLE;
					if (op == fsh_pkg::OP_POLL)
						next_state = fsh_pkg::CT_CHECK;
					else
						next_done = 1'b1;
				end
			end
			fsh_pkg::CT_CHECK: begin
				// Poll until the ready bit shows, then report errors
				if (rdata[fsh_pkg::READY_BIT]) begin
					next_done  = 1'b1;
					next_state = fsh_pkg::CT_IDLE;
					if ((rdata & fsh_pkg::ERR_MASK) != 16'h0000)
						next_err = 1'b1;
				end else begin
					next_start = 1'b1;
					next_state = fsh_pkg::CT_WAIT;
				end
			end
			default: next_state = fsh_pkg::CT_IDLE;
		endcase
		// Bus answer: one ack per request, data chosen by address
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		case (wb_adr_i)
			fsh_pkg::REG_CTRL:  next_dat = 32'(ctrl);
			fsh_pkg::REG_ADDR:  next_dat = 32'(addr);
			fsh_pkg::REG_WDATA: next_dat = 32'(wdata);
			fsh_pkg::REG_CMD:   next_dat = 32'(op);
			fsh_pkg::REG_RDATA: next_dat = 32'(rdata);
			fsh_pkg::REG_STAT:
				next_dat = 32'({refus, pulse, sts_s2, err, done,
					state != fsh_pkg::CT_IDLE});
			default: next_dat = 32'h00000000;
		endcase
	end

	// Registers; ready/busy reads as 1 when the pin floats high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= fsh_pkg::CTRL_RESET;
			addr     <= 24'h000000;
			wdata    <= 16'h0000;
			op       <= fsh_pkg::OP_READ;
			rdata    <= 16'h0000;
			done     <= 1'b0;
			err      <= 1'b0;
			pulse    <= 1'b0;
			refus    <= 1'b0;
			state    <= fsh_pkg::CT_IDLE;
			start    <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			width_sel_o            <= 1'b1;
			program_erase_enable_o <= 1'b0;
			reset_powerdown_n_o    <= 1'b0;
		end else begin
			ctrl     <= next_ctrl;
			addr     <= next_addr;
			wdata    <= next_wdata;
			op       <= next_op;
			rdata    <= next_rdata;
			done     <= next_done;
			err      <= next_err;
			pulse    <= next_pulse;
			refus    <= next_refus;
			state    <= next_state;
			start    <= next_start;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			width_sel_o            <= !next_ctrl[fsh_pkg::CTRL_X8];
			program_erase_enable_o <= next_ctrl[fsh_pkg::CTRL_PEEN];
			reset_powerdown_n_o    <= next_ctrl[fsh_pkg::CTRL_RUN];
		end
	end

	// Single strobe engine; one chip enable covers both dies
	fsh_bus_cycle u_cycle (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (start),
		.wr_i    (bc_wr),
		.addr_i  (pin_addr),
		.wdata_i (bc_wdata),
		.busy_o  (bc_busy),
		.done_o  (bc_done),
		.rdata_o (bc_rdata),
		.addr_o  (addr_o),
		.dq_o    (dq_o),
		.dq_oe_o (dq_oe_o),
		.dq_i    (dq_i),
		.ce_n_o  (ce_n_o),
		.oe_n_o  (oe_n_o),
		.we_n_o  (we_n_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	prog_needs_enable_a: assert property (
		start && op == fsh_pkg::OP_PROG |-> program_erase_enable_o)
		else $error("program without enable");
	count_in_range_a: assert property (
		start && op == fsh_pkg::OP_COUNT |-> bc_wdata < fsh_pkg::BUF_MAX)
		else $error("buffer count out of range");
	a0_low_x16_a: assert property (
		!ce_n_o && width_sel_o |-> !addr_o[0])
		else $error("A0 driven in 16-bit mode");
	ce_only_busy_a: assert property (
		!ce_n_o |-> bc_busy && !(!oe_n_o && !we_n_o))
		else $error("chip enable outside a cycle");
	die_select_a: assert property (
		start |=> ##1 addr_o[23] ==
		(ctrl[fsh_pkg::CTRL_X8] ? addr[23] : addr[22]))
		else $error("wrong die selected");
	read_done_c: cover property (state == fsh_pkg::CT_WAIT && bc_done
		&& op == fsh_pkg::OP_READ);
	poll_done_c: cover property (state == fsh_pkg::CT_CHECK
		&& rdata[fsh_pkg::READY_BIT]);
	refused_c: cover property (!refus ##1 refus);
endmodule : fsh_ctrl

// File: hw/fsh_pkg.sv
// Constants for the host controller of a stacked two-die parallel flash.
// Assumes a 200 MHz clock and a classic Wishbone slave with 32-bit data.
package fsh_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_ADDR  = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CMD   = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_STAT  = 8'h14;
	// CTRL fields and reset value
	localparam int CTRL_X8   = 0;
	localparam int CTRL_PEEN = 1;
	localparam int CTRL_RUN  = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// STAT fields
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_ERR   = 2;
	localparam int ST_STS   = 3;
	localparam int ST_PULSE = 4;
	localparam int ST_REFUS = 5;
	// Operation codes written to CMD
	localparam logic [2:0] OP_READ  = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_PROG  = 3'h2;
	localparam logic [2:0] OP_POLL  = 3'h3;
	localparam logic [2:0] OP_COUNT = 3'h4;
	// Buffer limits and flash status layout
	localparam logic [15:0] BUF_MAX   = 16'h0010;
	localparam int          READY_BIT = 7;
	localparam logic [15:0] ERR_MASK  = 16'h003A;
	// Bus timing
	localparam int CLK_MHZ    = 200;
	localparam int T_SETUP_NS = 10;
	localparam int T_PULSE_NS = 110;
	localparam int T_HOLD_NS  = 20;
	localparam int SYNC_CYC   = 2;
	localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC  = (T_PULSE_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
	localparam int HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam logic [5:0] SETUP_N = 6'(SETUP_CYC);
	localparam logic [5:0] PULSE_N = 6'(PULSE_CYC);
	localparam logic [5:0] HOLD_N  = 6'(HOLD_CYC);
	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_HOLD} fsh_bc_e;
	typedef enum logic [1:0] {CT_IDLE, CT_WAIT, CT_CHECK} fsh_ct_e;
endpackage : fsh_pkg

// File: hw/fsh_bus_cycle.sv
// One asynchronous flash bus cycle: setup, strobe pulse, hold.
// Assumes the data pins come from another domain; they are synchronised here.
module fsh_bus_cycle (
	input  wire logic        clk_i,     // System clock
	input  wire logic        rst_i,     // Synchronous reset
	input  wire logic        start_i,   // Begin a cycle
	input  wire logic        wr_i,      // 1 write, 0 read
	input  wire logic [23:0] addr_i,    // Pin address
	input  wire logic [15:0] wdata_i,   // Write data
	output logic             busy_o,    // Cycle in progress
	output logic             done_o,    // One-cycle end pulse
	output logic [15:0]      rdata_o,   // Captured read data
	output logic [23:0]      addr_o,    // Address pins
	output logic [15:0]      dq_o,      // Data pins out
	output logic             dq_oe_o,   // Data pin drive enable
	input  wire logic [15:0] dq_i,      // Data pins in
	output logic             ce_n_o,    // Chip enable, low active
	output logic             oe_n_o,    // Output enable, low active
	output logic             we_n_o     // Write strobe, low active
);
	fsh_pkg::fsh_bc_e state, next_state;
	logic [5:0]  cnt, next_cnt;
	logic        wr, next_wr;
	logic [15:0] dq_s1, dq_s2;

	// Two-stage synchroniser on the data pins
	always_ff @(posedge clk_i) begin
		dq_s1 <= dq_i;
		dq_s2 <= dq_s1;
	end

	// Next-state logic for the strobe sequence
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_wr    = wr;
		case (state)
			fsh_pkg::BC_IDLE: begin
				if (start_i) begin
					next_state = fsh_pkg::BC_SETUP;
					next_cnt   = fsh_pkg::SETUP_N;
					next_wr    = wr_i;
				end
			end
			fsh_pkg::BC_SETUP: begin
				next_cnt = cnt - 6'h01;
				if (cnt == 6'h01) begin
					next_state = fsh_pkg::BC_PULSE;
					next_cnt   = fsh_pkg::PULSE_N;
				end
			end
			fsh_pkg::BC_PULSE: begin
				next_cnt = cnt - 6'h01;
				if (cnt == 6'h01) begin
					next_state = fsh_pkg::BC_HOLD;
					next_cnt   = fsh_pkg::HOLD_N;
				end
			end
			fsh_pkg::BC_HOLD: begin
				next_cnt = cnt - 6'h01;
				if (cnt == 6'h01)
					next_state = fsh_pkg::BC_IDLE;
			end
			default: next_state = fsh_pkg::BC_IDLE;
		endcase
	end

	// Pins are registered so they never glitch between states
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state   <= fsh_pkg::BC_IDLE;
			cnt     <= 6'h00;
			wr      <= 1'b0;
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			rdata_o <= 16'h0000;
			addr_o  <= 24'h000000;
			dq_o    <= 16'h0000;
			dq_oe_o <= 1'b0;
			ce_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			wr      <= next_wr;
			busy_o  <= next_state != fsh_pkg::BC_IDLE;
			done_o  <= state == fsh_pkg::BC_HOLD && cnt == 6'h01;
			if (state == fsh_pkg::BC_IDLE && start_i) begin
				addr_o <= addr_i;
				dq_o   <= wdata_i;
			end
			// Data stays driven through hold so the latch edge sees it
			dq_oe_o <= next_wr && next_state != fsh_pkg::BC_IDLE;
			ce_n_o  <= next_state == fsh_pkg::BC_IDLE;
			oe_n_o  <= !(next_state == fsh_pkg::BC_PULSE && !next_wr);
			we_n_o  <= !(next_state == fsh_pkg::BC_PULSE && next_wr);
			// Sample late in the pulse, after synchroniser delay
			if (state == fsh_pkg::BC_PULSE && cnt == 6'h01 && !wr)
				rdata_o <= dq_s2;
		end
	end
endmodule : fsh_bus_cycle

// File: verification/fsh_flash_model.sv
// Behavioural two-die flash standing on the far side of the host controller.
// Assumes the bench resolves the data bus and pulls the status line up.
module fsh_flash_model #(
	parameter logic [15:0] CMD_WORD  = 16'h0011, // Arm one-word program
	parameter logic [15:0] CMD_ARRAY = 16'h0022, // Back to array reads
	parameter logic [15:0] CMD_CLRST = 16'h0033, // Clear error bits
	parameter logic [15:0] CMD_PSET  = 16'h0044, // Protect one block
	parameter logic [15:0] CMD_PCLR  = 16'h0055, // Unprotect every block
	parameter int          BUSY_NS   = 400       // Internal operation time
) (
	input  wire logic [23:0] addr_i,      // Address pins
	input  wire logic [15:0] dq_i,        // Resolved data bus
	output logic [15:0]      dq_o,        // Data driven on reads
	output logic             dq_oe_o,     // High while driving data
	input  wire logic        ce_n_i,      // Chip enable, low active
	input  wire logic        oe_n_i,      // Output enable, low active
	input  wire logic        we_n_i,      // Write strobe, low active
	input  wire logic        width_sel_i, // High for 16-bit bus
	input  wire logic        pe_en_i,     // Program/erase enable
	input  wire logic        rp_n_i,      // Reset and power-down, low
	output logic             sts_low_o,   // Pulls status line low
	output logic [23:0]      last_addr_o  // Address of last write
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [int];
	logic        prot [128];
	logic        armed;
	logic        stat_mode;
	logic        busy;
	logic [6:0]  err;
	event        go;
	// One address space for both dies; A0 is dropped in 16-bit mode
	function automatic int key_of(logic [23:0] a, logic w);
		return w ? int'({a[23:1], 1'b0}) : int'(a);
	endfunction : key_of
	// Every block starts protected, nothing pending
	initial begin
		foreach (prot[i]) prot[i] = 1'b1;
		armed = 0;
		stat_mode = 0;
		busy = 0;
		err = 0;
		last_addr_o = 0;
	end
	// Reset aborts work and clears status; protection is kept
	always @(negedge rp_n_i) begin
		armed = 0;
		stat_mode = 0;
		busy = 0;
		err = 0;
	end
	// Commands and data are latched on the strobe's rising edge
	always @(posedge we_n_i) begin
		if (!ce_n_i && rp_n_i) begin
			last_addr_o = addr_i;
			if (armed) begin
				armed = 0;
				stat_mode = 1;
				if (!pe_en_i) err[3] = 1;
				else if (prot[addr_i[23:17]]) err[4] = 1;
				else begin
					mem[key_of(addr_i, width_sel_i)] = width_sel_i ? dq_i : {8'h00, dq_i[7:0]};
					->go;
				end
			end else begin
				case (dq_i)
					CMD_WORD:  armed = 1;
					CMD_ARRAY: stat_mode = 0;
					CMD_CLRST: err = 0;
					CMD_PSET:  begin prot[addr_i[23:17]] = 1; stat_mode = 1; end
					CMD_PCLR:  begin foreach (prot[i]) prot[i] = 0; stat_mode = 1; ->go; end
					default:   ;
				endcase
			end
		end
	end
	// Internal controller busy time; a reset mid-way may cut it short
	always @(go) begin
		busy = 1;
		#BUSY_NS;
		busy = 0;
	end
	// Status register gives ready on bit 7 and the error bits below
	always @* begin
		sts_low_o = busy;
		dq_oe_o = !ce_n_i && !oe_n_i && we_n_i && rp_n_i;
		if (stat_mode) dq_o = {8'h00, !busy, err};
		else if (mem.exists(key_of(addr_i, width_sel_i))) dq_o = mem[key_of(addr_i, width_sel_i)];
		else dq_o = 16'hFFFF;
	end
endmodule : fsh_flash_model

// File: verification/testbench.sv
// Self-checking bench for the flash host controller and a flash model.
// Assumes the design's package is compiled first; read results queue up.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] C_WORD = 16'h0011, C_ARR = 16'h0022;
	localparam logic [15:0] C_CLR = 16'h0033, C_PSET = 16'h0044;
	localparam logic [15:0] C_PCLR = 16'h0055;
	logic clk = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
	logic [7:0] wb_adr = 0;
	logic [31:0] wb_dat = 0, rdat, e, m;
	logic ack, f_oe, ce_n, oe_n, we_n, wsel, pe_en, rp_n, m_oe, m_low;
	logic [23:0] f_addr, m_last, a_lo, a_hi, a8;
	logic [15:0] f_dq, m_q, d1, d2, dq_last = 0;
	logic [31:0] exp_q[$], msk_q[$], rs = 32'h6;
	int fails = 0, total_checks = 0;
	wire [15:0] dq_bus = f_oe ? f_dq : (m_oe ? m_q : ~dq_last);
	wire sts = m_low ? 1'b0 : 1'b1; // Pull-up on the open-drain line
	always #2.5 clk = ~clk;
	always @(posedge clk) dq_last <= dq_bus;
	fsh_ctrl dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.addr_o(f_addr), .dq_o(f_dq), .dq_oe_o(f_oe), .dq_i(dq_bus),
		.ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .width_sel_o(wsel),
		.program_erase_enable_o(pe_en), .reset_powerdown_n_o(rp_n),
		.status_ready_busy_out_i(sts));
	fsh_flash_model #(.CMD_WORD(C_WORD), .CMD_ARRAY(C_ARR),
		.CMD_CLRST(C_CLR), .CMD_PSET(C_PSET), .CMD_PCLR(C_PCLR))
		flash (.addr_i(f_addr), .dq_i(dq_bus), .dq_o(m_q), .dq_oe_o(m_oe),
		.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .width_sel_i(wsel),
		.pe_en_i(pe_en), .rp_n_i(rp_n), .sts_low_o(m_low),
		.last_addr_o(m_last));
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		chk(got, exp);
	endtask : chk_pin
	// Oldest note is matched to each read answer; mask 0 means no check
	always @(posedge clk) begin
		if (ack === 1'b1 && wb_we === 1'b0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			if (m != 0) chk(rdat & m, e & m);
		end
	end
	// Classic Wishbone cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		wb_cyc <= 1; wb_stb <= 1; wb_we <= w; wb_adr <= a; wb_dat <= d;
		n = 0;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 200);
		if (n >= 200) begin fails++; $display("ERROR %0t: no ack", $time); end
		q = rdat;
		wb_cyc <= 0; wb_stb <= 0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] mk, output logic [31:0] q);
		exp_q.push_back(x);
		msk_q.push_back(mk);
		wb(0, a, 0, q);
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] mk);
		logic [31:0] q;
		rd(a, x, mk, q);
	endtask : rdc
	// Start an operation, wait for done, check and clear the status
	task automatic op(input logic [2:0] c, input logic [23:0] a,
		input logic [15:0] d, input logic [31:0] es, input logic [31:0] em);
		logic [31:0] q;
		int n;
		wr(fsh_pkg::REG_ADDR, {8'h00, a});
		wr(fsh_pkg::REG_WDATA, {16'h0000, d});
		wr(fsh_pkg::REG_CMD, {29'h0, c});
		q = 0;
		n = 0;
		while (q[fsh_pkg::ST_DONE] !== 1'b1 && n < 100) begin
			rd(fsh_pkg::REG_STAT, 0, 0, q);
			n++;
		end
		if (n >= 100) begin fails++; $display("ERROR %0t: no done", $time); end
		rdc(fsh_pkg::REG_STAT, es, em);
		wr(fsh_pkg::REG_STAT, 32'h36);
	endtask : op
	task automatic fcmd(input logic [15:0] c, input logic [23:0] a);
		op(fsh_pkg::OP_WRITE, a, c, 32'h2, 32'h7);
	endtask : fcmd
	task automatic refuse(input logic [2:0] c, input logic [15:0] d);
		wr(fsh_pkg::REG_WDATA, {16'h0000, d});
		wr(fsh_pkg::REG_CMD, {29'h0, c});
		rdc(fsh_pkg::REG_STAT, 32'h20, 32'h20);
		wr(fsh_pkg::REG_STAT, 32'h36);
	endtask : refuse
	// Word program then poll; status pin is low while the flash works
	task automatic prog(input logic [23:0] a, input logic [15:0] d,
		input logic er);
		fcmd(C_CLR, a);
		fcmd(C_WORD, a);
		op(fsh_pkg::OP_PROG, a, d, er ? 32'hA : 32'h12,
			32'h1F);
		op(fsh_pkg::OP_POLL, a, 0, {28'h0, 1'b1, er, 2'b10}, 32'hF);
	endtask : prog
	task automatic rword(input logic [23:0] a, input logic [15:0] x);
		fcmd(C_ARR, a);
		op(fsh_pkg::OP_READ, a, 0, 32'h2, 32'h7);
		rdc(fsh_pkg::REG_RDATA, {16'h0000, x}, 32'hFFFF);
	endtask : rword
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// Watchdog well beyond the expected run of some 11 us
	initial begin
		#200000;
		fails++;
		$display("ERROR %0t: watchdog expired", $time);
		results();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk_pin(32'(rp_n), 32'h0);
		chk_pin(32'(wsel), 32'h1);
		rdc(fsh_pkg::REG_CTRL, 32'h0, 32'h7);
		rdc(fsh_pkg::REG_STAT, 32'h8, 32'h3F);
		wr(8'h40, 32'hFFFFFFFF);
		rdc(8'h40, 32'h0, 32'hFFFFFFFF);
		$display("test reset done");
		refuse(fsh_pkg::OP_READ, 0);
		wr(fsh_pkg::REG_CTRL, 32'h6);
		refuse(3'h5, 0);
		refuse(fsh_pkg::OP_COUNT, 16'd0);
		refuse(fsh_pkg::OP_COUNT, 16'd17);
		op(fsh_pkg::OP_COUNT, 0, 16'd1, 32'h2, 32'h27);
		op(fsh_pkg::OP_COUNT, 0, 16'd16, 32'h2, 32'h27);
		$display("test refuse done");
		a_lo = {1'b0, 7'h05, 16'(xs())};
		a_hi = a_lo | 24'h400000;
		d1 = 16'(xs());
		d2 = 16'(xs());
		prog(a_lo, d1, 1);
		fcmd(C_CLR, a_lo);
		fcmd(C_PCLR, a_lo);
		op(fsh_pkg::OP_POLL, a_lo, 0, 32'hA, 32'hF);
		prog(a_lo, d1, 0);
		chk_pin(32'(m_last), 32'({a_lo[22:0], 1'b0}));
		rword(a_lo, d1);
		rword(a_hi, 16'hFFFF);
		prog(a_hi, d2, 0);
		rword(a_hi, d2);
		rword(a_lo, d1);
		$display("test program done");
		wr(fsh_pkg::REG_CTRL, 32'h4);
		repeat (2) @(posedge clk);
		chk_pin(32'(pe_en), 32'h0);
		refuse(fsh_pkg::OP_PROG, d2);
		fcmd(C_CLR, a_lo);
		fcmd(C_WORD, a_lo);
		op(fsh_pkg::OP_WRITE, a_lo, d2, 32'hA, 32'hF);
		op(fsh_pkg::OP_POLL, a_lo, 0, 32'hE, 32'hF);
		rword(a_lo, d1);
		$display("test enable done");
		wr(fsh_pkg::REG_CTRL, 32'h6);
		fcmd(C_PSET, a_lo);
		wr(fsh_pkg::REG_CTRL, 32'h0);
		wr(fsh_pkg::REG_CTRL, 32'h6);
		prog(a_lo, d2, 1);
		rword(a_lo, d1);
		$display("test protect done");
		wr(fsh_pkg::REG_CTRL, 32'h7);
		repeat (2) @(posedge clk);
		chk_pin(32'(wsel), 32'h0);
		a8 = 24'(xs());
		fcmd(C_ARR, a8);
		chk_pin(32'(m_last), 32'(a8));
		$display("test byte mode done");
		results();
	end
endmodule : testbench
